// File: src/xfer_desc_pkg.sv
/*
 * Shared constants and carriers for the descriptor-driven transfer controller:
 * register map, descriptor layout, mode-word field positions, state codes.
 * Assumes a 32-bit APB master and a single-clock memory port with req/ack.
 */
package xfer_desc_pkg;
    // register byte offsets on APB
    localparam logic [7:0] OFS_BASE     = 8'h00;
    localparam logic [7:0] OFS_ENABLE   = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    // reset values
    localparam logic [15:0] BASE_RST    = 16'h0000;
    localparam logic [7:0]  ENABLE_RST  = 8'h00;
    // status word bit positions
    localparam int ST_NMI_POS   = 10;
    localparam int ST_AE_POS    = 9;
    localparam int ST_BUSY_POS  = 8;
    // mode word field positions
    localparam int SRC_MODE_HI  = 15;
    localparam int SRC_MODE_LO  = 14;
    localparam int DST_MODE_HI  = 13;
    localparam int DST_MODE_LO  = 12;
    localparam int KIND_HI      = 11;
    localparam int KIND_LO      = 10;
    localparam int SIZE_HI      = 9;
    localparam int SIZE_LO      = 8;
    localparam int SIDE_POS     = 7;
    localparam int CHAIN_POS    = 6;
    localparam int IRQ_ALL_POS  = 5;
    localparam int NMI_CONT_POS = 4;
    // descriptor layout: word offsets within one 16-byte descriptor
    localparam logic [31:0] DESC_W1     = 32'h0000_0004;
    localparam logic [31:0] DESC_W2     = 32'h0000_0008;
    localparam logic [31:0] DESC_W3     = 32'h0000_000c;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
    localparam logic [1:0] KIND_NORMAL = 2'h0;
    localparam logic [1:0] KIND_REPEAT = 2'h1;
    localparam logic [1:0] KIND_BLOCK  = 2'h2;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_F0 = 4'h1, S_F1 = 4'h2, S_F2 = 4'h3, S_F3 = 4'h4,
        S_RD = 4'h5, S_WR = 4'h6, S_WB0 = 4'h7, S_WB1 = 4'h8, S_WB2 = 4'h9, S_WB3 = 4'ha
    } st_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_s;
endpackage

// File: src/xfer_desc_ctrl.sv
/*
 * Descriptor-driven transfer controller: fetches a 16-byte descriptor from
 * memory, moves data units, updates addresses and counts, writes the
 * descriptor back, follows chains and signals the CPU interrupt logic.
 * Assumes one 250 MHz clock, an APB master for the registers, a memory that
 * answers each held request with a one-cycle ack, and level activation
 * requests from same-clock peripheral logic. The NMI pin is asynchronous.
 */
`timescale 1ns/1ps
module xfer_desc_ctrl
(
    input  wire logic                    CLK_IN,
    input  wire logic                    RSTN_IN,
    input  wire xfer_desc_pkg::apb_req_s APB_IN,
    output logic [31:0]                  PRDATA_OUT,
    output logic                         PREADY_OUT,
    output logic                         PSLVERR_OUT,
    output xfer_desc_pkg::mem_req_s      MEM_OUT,
    input  wire logic                    MEM_ACK_IN,
    input  wire logic [31:0]             MEM_RDATA_IN,
    input  wire logic [7:0]              ACT_REQ_IN,
    input  wire logic                    NMI_IN,
    output logic                         CPU_IRQ_OUT,
    output logic                         SRC_FLAG_CLR_OUT,
    output logic [2:0]                   SRC_ID_OUT
);
    import xfer_desc_pkg::*;

    typedef struct packed {
        st_e         state;
        logic [15:0] base;
        logic [7:0]  enable;
        logic        nmi_flag;
        logic        ae_flag;
        logic        nmi_armed;
        logic        ae_armed;
        logic        nmi_s1;
        logic        nmi_s2;
        logic        nmi_d;
        logic        halt;
        logic [2:0]  src;
        logic [31:0] desc_addr;
        logic [15:0] mode;
        logic [15:0] cnt_a;
        logic [31:0] sar;
        logic [31:0] dar;
        logic [31:0] word3;
        logic [16:0] blk_left;
        logic [31:0] blk_base;
        logic [31:0] data;
        mem_req_s    mem;
        logic        irq;
        logic        flag_clr;
    } state_s;

    state_s q_r;
    state_s q_nxt;
    logic   rst_s1_r;
    logic   rst_sync_r;

    // release edge resynchronised; assertion still immediate
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            rst_s1_r   <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_s1_r   <= 1'b1;
            rst_sync_r <= rst_s1_r;
        end
    end

    function automatic logic [31:0] unit_bytes(input logic [1:0] sz);
        case (sz)
            SZ_WORD: unit_bytes = 32'h0000_0002;
            SZ_LONG: unit_bytes = 32'h0000_0004;
            default: unit_bytes = 32'h0000_0001;
        endcase
    endfunction

    function automatic logic [31:0] step_addr(input logic [31:0] a, input logic hi, input logic lo,
                                              input logic [1:0] sz);
        if (!hi)
            step_addr = a;
        else if (!lo)
            step_addr = a + unit_bytes(sz);
        else
            step_addr = a - unit_bytes(sz);
    endfunction

    function automatic logic misaligned(input logic [31:0] a, input logic [1:0] sz);
        misaligned = (sz == SZ_WORD && a[0]) || (sz == SZ_LONG && a[1:0] != 2'h0);
    endfunction

    function automatic mem_req_s issue(input logic we, input logic [31:0] a, input logic [31:0] d,
                                       input logic [1:0] sz);
        issue.req   = 1'b1;
        issue.we    = we;
        issue.addr  = a;
        issue.wdata = d;
        issue.size  = sz;
    endfunction

    logic        apb_acc;
    logic        apb_wr;
    logic        apb_rd;
    logic        mapped;
    logic [31:0] status_word;
    logic [1:0]  kind;
    logic [1:0]  usz;
    logic        unit_end;
    logic        start;
    logic [2:0]  pick;
    logic        nmi_edge;

    // mode bits 3:0 are never decoded
    assign kind = q_r.mode[KIND_HI:KIND_LO];
    assign usz  = q_r.mode[SIZE_HI:SIZE_LO];

    assign apb_acc  = APB_IN.psel && APB_IN.penable;
    assign apb_wr   = apb_acc && APB_IN.pwrite;
    assign apb_rd   = apb_acc && !APB_IN.pwrite;
    assign mapped   = APB_IN.paddr == OFS_BASE || APB_IN.paddr == OFS_ENABLE || APB_IN.paddr == OFS_STATUS;
    assign nmi_edge = q_r.nmi_s2 && !q_r.nmi_d;
    assign unit_end = q_r.state == S_WR && MEM_ACK_IN && q_r.blk_left == 17'h00001;
    // no new activation while a flag stands
    assign start    = q_r.state == S_IDLE && |(ACT_REQ_IN & q_r.enable) && !q_r.nmi_flag && !q_r.ae_flag;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_NMI_POS]  = q_r.nmi_flag;
        status_word[ST_AE_POS]   = q_r.ae_flag;
        status_word[ST_BUSY_POS] = q_r.state != S_IDLE;
        status_word[2:0]         = q_r.src;
    end

    // lowest-numbered pending source wins
    always_comb
    begin
        pick = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (ACT_REQ_IN[i] && q_r.enable[i])
                pick = 3'(i);
        end
    end

    // descriptor working copies are absent from the map
    always_comb
    begin
        PREADY_OUT  = 1'b1;
        PSLVERR_OUT = apb_acc && !mapped;
        case (APB_IN.paddr)
            OFS_BASE:   PRDATA_OUT = {16'h0000, q_r.base};
            OFS_ENABLE: PRDATA_OUT = {24'h000000, q_r.enable};
            OFS_STATUS: PRDATA_OUT = status_word;
            default:    PRDATA_OUT = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        q_nxt          = q_r;
        q_nxt.irq      = 1'b0;
        q_nxt.flag_clr = 1'b0;
        q_nxt.nmi_s1   = NMI_IN;
        q_nxt.nmi_s2   = q_r.nmi_s1;
        q_nxt.nmi_d    = q_r.nmi_s2;
        if (MEM_ACK_IN)
            q_nxt.mem.req = 1'b0;

        if (apb_wr && APB_IN.paddr == OFS_BASE)
            q_nxt.base = APB_IN.pwdata[15:0];
        if (apb_wr && APB_IN.paddr == OFS_ENABLE)
            q_nxt.enable = APB_IN.pwdata[7:0];
        // a zero write only counts after the flag was read as one
        if (apb_rd && APB_IN.paddr == OFS_STATUS)
        begin
            q_nxt.nmi_armed = q_r.nmi_armed || q_r.nmi_flag;
            q_nxt.ae_armed  = q_r.ae_armed || q_r.ae_flag;
        end
        if (apb_wr && APB_IN.paddr == OFS_STATUS)
        begin
            if (q_r.nmi_armed && !APB_IN.pwdata[ST_NMI_POS])
            begin
                q_nxt.nmi_flag  = 1'b0;
                q_nxt.nmi_armed = 1'b0;
            end
            if (q_r.ae_armed && !APB_IN.pwdata[ST_AE_POS])
            begin
                q_nxt.ae_flag  = 1'b0;
                q_nxt.ae_armed = 1'b0;
            end
        end
        // a new NMI beats a clear in the same cycle
        if (nmi_edge)
        begin
            q_nxt.nmi_flag = 1'b1;
            if (q_r.state != S_IDLE)
                q_nxt.halt = 1'b1;
        end

        // abort completes the bus cycle in flight, then drops everything
        if (q_r.halt && MEM_ACK_IN && q_r.state != S_IDLE && q_r.state != S_F0 && !q_r.mode[NMI_CONT_POS])
        begin
            q_nxt.state = S_IDLE;
        end
        else
        begin
            case (q_r.state)
                S_IDLE:
                begin
                    // an NMI edge in the start cycle must still reach the transfer it would miss
                    q_nxt.halt = nmi_edge;
                    if (start)
                    begin
                        q_nxt.src       = pick;
                        q_nxt.desc_addr = {q_r.base, 16'h0000} + {21'h000000, pick, 8'h00};
                        q_nxt.mem       = issue(1'b0, q_nxt.desc_addr, 32'h0, SZ_LONG);
                        q_nxt.state     = S_F0;
                    end
                end
                S_F0:
                if (MEM_ACK_IN)
                begin
                    q_nxt.mode  = MEM_RDATA_IN[31:16];
                    q_nxt.cnt_a = MEM_RDATA_IN[15:0];
                    if (q_r.halt && !MEM_RDATA_IN[16 + NMI_CONT_POS])
                        q_nxt.state = S_IDLE;
                    else
                    begin
                        q_nxt.mem   = issue(1'b0, q_r.desc_addr + DESC_W1, 32'h0, SZ_LONG);
                        q_nxt.state = S_F1;
                    end
                end
                S_F1:
                if (MEM_ACK_IN)
                begin
                    q_nxt.sar   = MEM_RDATA_IN;
                    q_nxt.mem   = issue(1'b0, q_r.desc_addr + DESC_W2, 32'h0, SZ_LONG);
                    q_nxt.state = S_F2;
                end
                S_F2:
                if (MEM_ACK_IN)
                begin
                    q_nxt.dar   = MEM_RDATA_IN;
                    q_nxt.mem   = issue(1'b0, q_r.desc_addr + DESC_W3, 32'h0, SZ_LONG);
                    q_nxt.state = S_F3;
                end
                S_F3:
                if (MEM_ACK_IN)
                begin
                    // word3 holds the initial address in repeat mode, block length above in block mode
                    q_nxt.word3    = MEM_RDATA_IN;
                    q_nxt.blk_left = (kind == KIND_BLOCK) ? {MEM_RDATA_IN[31:16] == 16'h0000, MEM_RDATA_IN[31:16]}
                                                          : 17'h00001;
                    q_nxt.blk_base = q_r.mode[SIDE_POS] ? q_r.sar : q_r.dar;
                    // misaligned unit address is an address error and stops the controller
                    if (misaligned(q_r.sar, usz) || misaligned(q_r.dar, usz))
                    begin
                        q_nxt.ae_flag = 1'b1;
                        q_nxt.state   = S_IDLE;
                    end
                    else
                    begin
                        q_nxt.mem   = issue(1'b0, q_r.sar, 32'h0, usz);
                        q_nxt.state = S_RD;
                    end
                end
                S_RD:
                if (MEM_ACK_IN)
                begin
                    q_nxt.data  = MEM_RDATA_IN;
                    q_nxt.mem   = issue(1'b1, q_r.dar, MEM_RDATA_IN, usz);
                    q_nxt.state = S_WR;
                end
                S_WR:
                if (MEM_ACK_IN)
                begin
                    q_nxt.sar      = step_addr(q_r.sar, q_r.mode[SRC_MODE_HI], q_r.mode[SRC_MODE_LO], usz);
                    q_nxt.dar      = step_addr(q_r.dar, q_r.mode[DST_MODE_HI], q_r.mode[DST_MODE_LO], usz);
                    q_nxt.blk_left = q_r.blk_left - 17'h00001;
                    if (!unit_end)
                    begin
                        q_nxt.mem   = issue(1'b0, q_nxt.sar, 32'h0, usz);
                        q_nxt.state = S_RD;
                    end
                    else
                    begin
                        case (kind)
                            KIND_REPEAT:
                            begin
                                q_nxt.cnt_a[7:0] = q_r.cnt_a[7:0] - 8'h01;
                                if (q_nxt.cnt_a[7:0] == 8'h00)
                                begin
                                    q_nxt.cnt_a[7:0] = q_r.cnt_a[15:8];
                                    if (q_r.mode[SIDE_POS])
                                        q_nxt.sar = q_r.word3;
                                    else
                                        q_nxt.dar = q_r.word3;
                                end
                            end
                            KIND_BLOCK:
                            begin
                                q_nxt.cnt_a = q_r.cnt_a - 16'h0001;
                                if (q_r.mode[SIDE_POS])
                                    q_nxt.sar = q_r.blk_base;
                                else
                                    q_nxt.dar = q_r.blk_base;
                            end
                            default:
                                q_nxt.cnt_a = q_r.cnt_a - 16'h0001;
                        endcase
                        // repeat mode never runs out, so only its per-transfer request applies
                        if (q_r.mode[IRQ_ALL_POS] || (kind != KIND_REPEAT && q_nxt.cnt_a == 16'h0000))
                        begin
                            q_nxt.irq            = 1'b1;
                            q_nxt.enable[q_r.src] = 1'b0;
                        end
                        else
                            q_nxt.flag_clr = 1'b1;
                        q_nxt.mem   = issue(1'b1, q_r.desc_addr, {q_r.mode, q_nxt.cnt_a}, SZ_LONG);
                        q_nxt.state = S_WB0;
                    end
                end
                S_WB0:
                if (MEM_ACK_IN)
                begin
                    q_nxt.mem   = issue(1'b1, q_r.desc_addr + DESC_W1, q_r.sar, SZ_LONG);
                    q_nxt.state = S_WB1;
                end
                S_WB1:
                if (MEM_ACK_IN)
                begin
                    q_nxt.mem   = issue(1'b1, q_r.desc_addr + DESC_W2, q_r.dar, SZ_LONG);
                    q_nxt.state = S_WB2;
                end
                S_WB2:
                if (MEM_ACK_IN)
                begin
                    q_nxt.mem   = issue(1'b1, q_r.desc_addr + DESC_W3, q_r.word3, SZ_LONG);
                    q_nxt.state = S_WB3;
                end
                S_WB3:
                if (MEM_ACK_IN)
                begin
                    // an NMI in continue mode ends the activation here rather than chaining on
                    if (q_r.mode[CHAIN_POS] && !q_r.halt)
                    begin
                        q_nxt.desc_addr = q_r.desc_addr + DESC_STRIDE;
                        q_nxt.mem       = issue(1'b0, q_nxt.desc_addr, 32'h0, SZ_LONG);
                        q_nxt.state     = S_F0;
                    end
                    else
                        q_nxt.state = S_IDLE;
                end
                default:
                    q_nxt.state = S_IDLE;
            endcase
        end
        if (q_nxt.state == S_IDLE)
            q_nxt.mem.req = 1'b0;
    end

    always_ff @(posedge CLK_IN or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            q_r        <= '0;
            q_r.state  <= S_IDLE;
            q_r.base   <= BASE_RST;
            q_r.enable <= ENABLE_RST;
        end
        else
            q_r <= q_nxt;
    end

    assign MEM_OUT          = q_r.mem;
    assign CPU_IRQ_OUT      = q_r.irq;
    assign SRC_FLAG_CLR_OUT = q_r.flag_clr;
    assign SRC_ID_OUT       = q_r.src;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!rst_sync_r);

    logic [31:0] step_now;
    assign step_now = unit_bytes(usz);

    a_src_incr_step: assert property (unit_end && kind == KIND_NORMAL && q_r.mode[15:14] == 2'b10
        && !(q_r.halt && !q_r.mode[4]) |=> q_r.sar == $past(q_r.sar) + $past(step_now))
        else $error("source did not step up");
    a_src_fixed_hold: assert property (unit_end && kind == KIND_NORMAL && !q_r.mode[15]
        |=> q_r.sar == $past(q_r.sar)) else $error("fixed source moved");
    a_dst_decr_step: assert property (unit_end && kind == KIND_NORMAL && q_r.mode[13:12] == 2'b11
        && !(q_r.halt && !q_r.mode[4]) |=> q_r.dar == $past(q_r.dar) - $past(step_now))
        else $error("destination did not step down");
    a_chain_next_fetch: assert property (q_r.state == S_WB3 && MEM_ACK_IN && q_r.mode[6] && !q_r.halt
        |=> q_r.state == S_F0 && MEM_OUT.req && MEM_OUT.addr == $past(q_r.desc_addr) + 32'h10)
        else $error("chain fetch address wrong");
    a_no_chain_idle: assert property (q_r.state == S_WB3 && MEM_ACK_IN && !q_r.mode[6]
        |=> q_r.state == S_IDLE ##1 q_r.state == S_IDLE || $past(start)) else $error("ran past end");
    a_irq_each_xfer: assert property (unit_end && q_r.mode[5] && !(q_r.halt && !q_r.mode[4])
        |=> CPU_IRQ_OUT && !SRC_FLAG_CLR_OUT && !q_r.enable[q_r.src]) else $error("no interrupt");
    a_irq_withheld: assert property (unit_end && !q_r.mode[5] && kind == KIND_NORMAL
        && q_r.cnt_a != 16'h0001 && !(q_r.halt && !q_r.mode[4]) |=> !CPU_IRQ_OUT && SRC_FLAG_CLR_OUT)
        else $error("interrupt leaked");
    a_flags_refuse: assert property (q_r.state == S_IDLE && (q_r.nmi_flag || q_r.ae_flag)
        |=> q_r.state == S_IDLE) else $error("started under flag");
    a_flag_needs_read: assert property (apb_wr && APB_IN.paddr == OFS_STATUS && q_r.nmi_flag
        && !q_r.nmi_armed |=> q_r.nmi_flag) else $error("flag cleared without read");
    a_rep_reload: assert property (unit_end && kind == KIND_REPEAT && q_r.cnt_a[7:0] == 8'h01
        && !(q_r.halt && !q_r.mode[4]) |=> q_r.cnt_a[7:0] == $past(q_r.cnt_a[15:8]))
        else $error("repeat counter not reloaded");
    a_nmi_abort: assert property (q_r.halt && MEM_ACK_IN && !q_r.mode[4] && q_r.state inside {[S_F1:S_WB3]}
        |=> q_r.state == S_IDLE && !MEM_OUT.req) else $error("abort not taken");

    c_chain: cover property (q_r.state == S_WB3 && MEM_ACK_IN && q_r.mode[6] ##1 q_r.state == S_F0);
    c_repeat_reload: cover property (unit_end && kind == KIND_REPEAT && q_r.cnt_a[7:0] == 8'h01);
    c_block_multi: cover property (q_r.state == S_WR && MEM_ACK_IN && q_r.blk_left > 17'h00001);
    c_addr_error: cover property (q_r.state == S_F3 ##1 q_r.ae_flag);
endmodule

// File: verification/mem_model.sv
/* behavioural system memory on the controller's request/ack port, byte addressed
   assumes a request and its qualifiers hold until the edge that acks it */
`timescale 1ns/1ps
module mem_model
(
    input  wire logic                    clk_in,
    input  wire logic                    rstn_in,
    input  wire xfer_desc_pkg::mem_req_s req_in,
    output logic                         ack_out,
    output logic [31:0]                  rdata_out
);
    import xfer_desc_pkg::*;
    logic [7:0] mem [int unsigned];
    int         lat = 0;
    int         cnt = 0;
    initial ack_out = 1'b0;
    initial rdata_out = 32'h0;
    // data toggles when not acked so a stale word is never taken for a fresh one
    always @(posedge clk_in)
    begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        if (rstn_in && req_in.req && !ack_out && cnt < lat)
            cnt <= cnt + 1;
        else if (rstn_in && req_in.req && !ack_out)
        begin
            cnt <= 0;
            ack_out <= 1'b1;
            rdata_out <= 32'h0;
            for (int i = 0; i < (1 << req_in.size); i++)
                if (req_in.we)
                    mem[req_in.addr + i] = req_in.wdata[8*i +: 8];
                else
                    rdata_out[8*i +: 8] <= mem[req_in.addr + i];
        end
    end
endmodule

// File: verification/tb.sv
/* self-checking bench for xfer_desc_ctrl: descriptor rows, register reset, flag handling
   assumes the package register map and a descriptor table at base 1 (address 0x10000) */
`timescale 1ns/1ps
module tb;
    import xfer_desc_pkg::*;
    typedef struct packed {logic [15:0] m, c; logic [31:0] w3, s, d, es, ed; logic [15:0] ec; logic q, en;} row_s;
    row_s rows [6] = '{ // aligned addresses and repeat start loaded by software
        '{16'ha200, 16'h0002, 32'h0, 32'h2010, 32'h3010, 32'h2014, 32'h3014, 16'h0001, 1'b0, 1'b1},
        '{16'hc100, 16'h0001, 32'h0, 32'h2020, 32'h3020, 32'h201e, 32'h3020, 16'h0000, 1'b1, 1'b0},
        '{16'h3000, 16'h0000, 32'h0, 32'h2031, 32'h3031, 32'h2031, 32'h3030, 16'hffff, 1'b0, 1'b1},
        '{16'ha02f, 16'h0005, 32'h0, 32'h2041, 32'h3041, 32'h2042, 32'h3042, 16'h0004, 1'b1, 1'b0},
        '{16'ha600, 16'h0201, 32'h3050, 32'h2050, 32'h3054, 32'h2054, 32'h3050, 16'h0202, 1'b0, 1'b1},
        '{16'haa80, 16'h0001, 32'h20000, 32'h2060, 32'h3060, 32'h2060, 32'h3068, 16'h0000, 1'b1, 1'b0}};
    logic        clk = 1'b0, rstn = 1'b0, nmi = 1'b0, ack, irq, fclr, rdy, serr, se;
    logic [7:0]  act = 8'h00;
    logic [2:0]  sid;
    logic [31:0] rd, q, mdat, d4 [4];
    apb_req_s    apb = '0;
    mem_req_s    mreq;
    row_s        r;
    int          err_total = 0, n_checks = 0, nev = 0, nirq = 0, nreq = 0, e0, i0, n;
    xfer_desc_ctrl xfer_desc_ctrl_i (.CLK_IN(clk), .RSTN_IN(rstn), .APB_IN(apb), .PRDATA_OUT(rd), .PREADY_OUT(rdy),
        .PSLVERR_OUT(serr), .MEM_OUT(mreq), .MEM_ACK_IN(ack), .MEM_RDATA_IN(mdat), .ACT_REQ_IN(act),
        .NMI_IN(nmi), .CPU_IRQ_OUT(irq), .SRC_FLAG_CLR_OUT(fclr), .SRC_ID_OUT(sid));
    mem_model mem_model_i (.clk_in(clk), .rstn_in(rstn), .req_in(mreq), .ack_out(ack), .rdata_out(mdat));
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        nev <= nev + (irq === 1'b1) + (fclr === 1'b1);
        nirq <= nirq + (irq === 1'b1);
        nreq <= nreq + (mreq.req === 1'b1);
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            err_total++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = rd;
        se = serr;
        apb <= '0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] rdw(input logic [31:0] a, input int k);
        rdw = 32'h0;
        for (int i = 0; i < k; i++)
            rdw[8*i +: 8] = mem_model_i.mem[a + i];
    endfunction
    task automatic put(input logic [31:0] a, w0, w1, w2, w3);
        d4 = '{w0, w1, w2, w3};
        for (int k = 0; k < 16; k++)
            mem_model_i.mem[a + k] = d4[k / 4][8*(k % 4) +: 8];
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        // a few hundred cycles are expected; allow about ten thousand
        #40000;
        err_total++;
        conclude();
    end
    initial
    begin
        for (int a = 0; a < 256; a++)
        begin
            mem_model_i.mem[32'h2000 + a] = a[7:0] ^ 8'h5a;
            mem_model_i.mem[32'h3000 + a] = 8'h00;
        end
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        for (int a = 0; a < 16; a += 4)
        begin
            bus(1'b0, a[7:0], 32'h0);
            chk("reset read", 32'h0, q);
            chk("slave error", {31'h0, a == 12}, {31'h0, se});
        end
        $display("register reset test done");
        bus(1'b1, OFS_BASE, 32'h1);
        foreach (rows[i])
        begin
            r = rows[i];
            put(32'h10000, {r.m, r.c}, r.s, r.d, r.w3);
            mem_model_i.lat = i % 2;
            bus(1'b1, OFS_ENABLE, 32'h1);
            e0 = nev;
            i0 = nirq;
            n = 1 << r.m[9:8];
            act <= 8'h01;
            while (nev == e0) @(posedge clk);
            act <= 8'h00;
            while (mreq.req !== 1'b0) @(posedge clk);
            @(posedge clk);
            chk("count", {16'h0, r.ec}, rdw(32'h10000, 2));
            chk("source", r.es, rdw(32'h10004, 4));
            chk("destination", r.ed, rdw(32'h10008, 4));
            chk("data", rdw(r.s, n), rdw(r.d, n));
            chk("cpu irq", {31'h0, r.q}, nirq - i0);
            chk("flag clear", {31'h0, !r.q}, (nev - e0) - (nirq - i0));
            chk("source id", 32'h0, {29'h0, sid});
            bus(1'b0, OFS_ENABLE, 32'h0);
            chk("enable", {31'h0, r.en}, q);
            $display("row %0d done", i);
        end
        // chain: one byte, then the descriptor 16 bytes on moves another
        put(32'h10000, 32'ha040_0001, 32'h2070, 32'h3070, 32'h0);
        put(32'h10010, 32'ha000_0002, 32'h2080, 32'h3080, 32'h0);
        bus(1'b1, OFS_ENABLE, 32'h1);
        e0 = nev;
        act <= 8'h01;
        while (nev - e0 < 2) @(posedge clk);
        act <= 8'h00;
        while (mreq.req !== 1'b0) @(posedge clk);
        @(posedge clk);
        chk("first count", 32'h0, rdw(32'h10000, 2));
        chk("chained count", 32'h1, rdw(32'h10010, 2));
        chk("chained destination", 32'h3081, rdw(32'h10018, 4));
        chk("chained data", rdw(32'h2080, 1), rdw(32'h3080, 1));
        $display("chain test done");
        // slow memory so the NMI lands during the descriptor fetch
        put(32'h10000, 32'ha000_0003, 32'h2090, 32'h3090, 32'h0);
        mem_model_i.lat = 3;
        bus(1'b1, OFS_ENABLE, 32'h1);
        act <= 8'h01;
        repeat (6) @(posedge clk);
        act <= 8'h00;
        nmi <= 1'b1;
        repeat (4) @(posedge clk);
        nmi <= 1'b0;
        while (mreq.req !== 1'b0) @(posedge clk);
        @(posedge clk);
        chk("aborted count", 32'h3, rdw(32'h10000, 2));
        chk("aborted data", 32'h0, rdw(32'h3090, 1));
        $display("abort test done");
        nmi <= 1'b1;
        repeat (4) @(posedge clk);
        nmi <= 1'b0;
        bus(1'b1, OFS_ENABLE, 32'h1);
        i0 = nreq;
        act <= 8'h01;
        repeat (20) @(posedge clk);
        act <= 8'h00;
        chk("refused", 32'h0, nreq - i0);
        bus(1'b1, OFS_STATUS, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("flag kept", 32'h1, {31'h0, q[ST_NMI_POS]});
        bus(1'b1, OFS_STATUS, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("flag cleared", 32'h0, {31'h0, q[ST_NMI_POS]});
        $display("flag test done");
        conclude();
    end
endmodule
